// *** inc/dps_pkg.sv ***
// Constants and types shared by both ends of the pin control and power sequencer link.
// Assumes a single 200 MHz ref_clk in each end and pins resolved by dps_link_if.
// Operation
// - Low mute pin mutes, high plays.
// - Format pin: low LJ, high I2S, float RJ.
// - Mute acts on both channels equally.
// - Mute ramps gain down over 800 samples.
// - Unmute restores full gain in one step.
// - Off to enabled: clocks running, mute high.
// - Off to standby: clocks running, mute low.
// - Standby holds when bit clock stops.
// - Standby to enabled: mute high, bit clock.
// - Enabled to standby on mute or no bit clock.
// - Host keeps master clock through that transition.
// - Leaving enabled: mute first, then power down.
// - Master clock loss drops to off anywhere.
// - Host enters standby before stopping master clock; the host stops it MCLK_STOP_GUARD_CYC cycles after forcing mute, mid-ramp.
// - Host holds standby across fast rate changes.
// - 128fs and 192fs use the narrow filter.
// - Bit clock monitor mutes and drops to standby.
// - Host sources bit, frame clock, data MSB first.
package dps_pkg;
  localparam int REF_CLK_MHZ = 200;
  localparam int SYNC_W = 6;
  localparam int GAIN_W = 10;
  localparam int MUTE_RAMP_SAMPLES = 800;
  localparam logic [GAIN_W-1:0] GAIN_FULL = 10'h320;
  localparam logic [GAIN_W-1:0] GAIN_SILENT = 10'h000;
  localparam int WD_W = 7;
  localparam logic [WD_W-1:0] MCLK_TIMEOUT_CYC = 7'h40;
  localparam logic [WD_W-1:0] BCLK_TIMEOUT_MCLK = 7'h40;
  localparam int RATIO_W = 11;
  localparam logic [RATIO_W-1:0] RATIO_NARROW_MAX = 11'h0e0;
  localparam logic [RATIO_W-1:0] RATIO_SAT = 11'h7ff;
  localparam logic [7:0] FALLBACK_MCLK_PER_SAMPLE_M1 = 8'hff;
  localparam int MCLK_HALF_CYC = 2;
  localparam int BCLK_HALF_CYC = 8;
  localparam int BITS_PER_SLOT = 32;
  localparam int SAMPLE_W = 24;
  localparam int RATE_GUARD_FRAMES = 1026;
  localparam int MCLK_STOP_GUARD_NS = 20000;
  localparam int MCLK_STOP_GUARD_CYC = (MCLK_STOP_GUARD_NS * REF_CLK_MHZ) / 1000;

  typedef enum logic [3:0] {
    DPS_OFF = 4'b0001,
    DPS_STANDBY = 4'b0010,
    DPS_ENABLED = 4'b0100,
    DPS_MUTING = 4'b1000
  } dps_state_t;

  typedef enum logic [1:0] {
    DPS_FMT_LJ = 2'h0,
    DPS_FMT_I2S = 2'h1,
    DPS_FMT_RJ = 2'h2
  } dps_fmt_t;
endpackage : dps_pkg

// *** inc/dps_link_if.sv ***
// Pin-level link between the host controller and the converter control logic.
// Assumes both ends run on the same ref_clk; the format pin is resolved here.
`timescale 1ns/10ps
interface dps_link_if;
  logic mclk;
  logic bclk;
  logic lrclk;
  logic serial_audio_input;
  logic mute_n;
  logic format_select_pin_o;
  logic format_select_pin_oe;
  logic fmt_level;
  logic fmt_driven;

  // A floating pin reads low with the driven flag clear, so the device sees three levels.
  assign fmt_level = format_select_pin_oe & format_select_pin_o;
  assign fmt_driven = format_select_pin_oe;

  modport host (
    output mclk,
    output bclk,
    output lrclk,
    output serial_audio_input,
    output mute_n,
    output format_select_pin_o,
    output format_select_pin_oe
  );

  modport dev (
    input mclk,
    input bclk,
    input lrclk,
    input serial_audio_input,
    input mute_n,
    input fmt_level,
    input fmt_driven
  );
endinterface : dps_link_if

// *** rtl/dps_device.sv ***
// Control pin decoding, clock watchdogs, power-state sequencer and soft mute gain.
// Assumes every clock and control link pin is asynchronous to ref_clk and passes the synchroniser first.
`timescale 1ns/10ps
module dps_device
  import dps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  dps_link_if.dev link,
  output dps_state_t power_state,
  output logic charge_pump_on,
  output logic output_path_on,
  output logic [GAIN_W-1:0] gain_left,
  output logic [GAIN_W-1:0] gain_right,
  output dps_fmt_t audio_format,
  output logic filter_narrow,
  output logic mclk_ok,
  output logic bclk_ok
);
  logic [SYNC_W-1:0] pin_async;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync3;
  logic [WD_W-1:0] mclk_wd;
  logic [WD_W-1:0] bclk_wd;
  logic [RATIO_W-1:0] ratio_cnt;
  logic [7:0] fallback_cnt;
  logic [GAIN_W-1:0] gain;
  dps_state_t state;
  dps_state_t next_state;
  logic [GAIN_W-1:0] next_gain;
  dps_fmt_t next_format;

  assign pin_async = {link.fmt_driven, link.fmt_level, link.mute_n, link.lrclk,
                      link.bclk, link.mclk};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge ref_clk)
      begin
        if (!rstn)
        begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
        end
        else
        begin
          sync1[gi] <= pin_async[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
        end
      end
    end
  endgenerate

  wire mclk_rise = sync2[0] & ~sync3[0];
  wire bclk_edge = sync2[1] ^ sync3[1];
  wire lr_rise = sync2[2] & ~sync3[2];
  wire mute_n_s = sync2[3];
  wire fmt_level_s = sync2[4];
  wire fmt_driven_s = sync2[5];

  // Watchdogs start expired, so nothing leaves off until both clocks are really seen.
  wire mclk_alive = mclk_wd != MCLK_TIMEOUT_CYC;
  wire bclk_alive = mclk_alive && (bclk_wd != BCLK_TIMEOUT_MCLK);
  wire fallback_tick = mclk_rise && (fallback_cnt == FALLBACK_MCLK_PER_SAMPLE_M1);
  // Without a bit clock the frame clock is likely dead too, so a tick every 256 master clock rises paces the ramp.
  wire sample_tick = bclk_alive ? lr_rise : fallback_tick;

  always_comb
  begin
    next_state = state;
    unique case (state)
      DPS_OFF:
      begin
        if (bclk_alive)
          next_state = mute_n_s ? DPS_ENABLED : DPS_STANDBY;
      end
      DPS_STANDBY:
      begin
        if (mute_n_s && bclk_alive)
          next_state = DPS_ENABLED;
      end
      DPS_ENABLED:
      begin
        if (!mute_n_s || !bclk_alive)
          next_state = DPS_MUTING;
      end
      DPS_MUTING:
      begin
        // Releasing mute mid-ramp returns to full gain at once instead of finishing the ramp.
        if (mute_n_s && bclk_alive)
          next_state = DPS_ENABLED;
        else if (gain == GAIN_SILENT)
          next_state = DPS_STANDBY;
      end
      default:
        next_state = DPS_OFF;
    endcase
    if (!mclk_alive)
      next_state = DPS_OFF;
  end

  always_comb
  begin
    next_gain = gain;
    if (next_state == DPS_ENABLED)
      next_gain = GAIN_FULL;
    else if (next_state == DPS_MUTING)
    begin
      if (sample_tick && gain != GAIN_SILENT)
        next_gain = gain - 10'h001;
    end
    else
      next_gain = GAIN_SILENT;
  end

  assign next_format = !fmt_driven_s ? DPS_FMT_RJ : (fmt_level_s ? DPS_FMT_I2S : DPS_FMT_LJ);

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      mclk_wd <= MCLK_TIMEOUT_CYC;
      bclk_wd <= BCLK_TIMEOUT_MCLK;
    end
    else
    begin
      if (mclk_rise)
        mclk_wd <= '0;
      else if (mclk_alive)
        mclk_wd <= mclk_wd + 7'h01;
      if (!mclk_alive)
        bclk_wd <= BCLK_TIMEOUT_MCLK;
      else if (bclk_edge)
        bclk_wd <= '0;
      else if (mclk_rise && bclk_alive)
        bclk_wd <= bclk_wd + 7'h01;
    end
  end

  // The ratio is counted in master clock rises per frame; 128fs and 192fs stay under the limit.
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      ratio_cnt <= '0;
      fallback_cnt <= '0;
      filter_narrow <= 1'b0;
    end
    else
    begin
      if (lr_rise)
      begin
        filter_narrow <= ratio_cnt <= RATIO_NARROW_MAX;
        ratio_cnt <= '0;
      end
      else if (mclk_rise && ratio_cnt != RATIO_SAT)
        ratio_cnt <= ratio_cnt + 11'h001;
      if (mclk_rise)
        fallback_cnt <= fallback_cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state <= DPS_OFF;
      power_state <= DPS_OFF;
      gain <= GAIN_SILENT;
      charge_pump_on <= 1'b0;
      output_path_on <= 1'b0;
      audio_format <= DPS_FMT_LJ;
      mclk_ok <= 1'b0;
      bclk_ok <= 1'b0;
    end
    else
    begin
      state <= next_state;
      power_state <= next_state;
      gain <= next_gain;
      charge_pump_on <= next_state != DPS_OFF;
      output_path_on <= next_state == DPS_ENABLED || next_state == DPS_MUTING;
      audio_format <= next_format;
      mclk_ok <= mclk_alive;
      bclk_ok <= bclk_alive;
    end
  end

  // One gain register feeds both channels, so they can never disagree.
  assign gain_left = gain;
  assign gain_right = gain;
endmodule : dps_device

// *** rtl/dps_host.sv ***
// Host side: makes the master, bit and frame clocks, shifts audio, drives control pins.
// Assumes a single ref_clk; all clocks are divided from it and leave as plain outputs.
`timescale 1ns/10ps
module dps_host
  import dps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  dps_link_if.host link,
  input wire logic mclk_run,
  input wire logic bclk_run,
  input wire logic mute_req,
  input wire dps_fmt_t fmt_req,
  input wire logic rate_change,
  input wire logic [SAMPLE_W-1:0] audio_word,
  output logic mclk_active,
  output logic hold_active
);
  logic [3:0] mdiv;
  logic [3:0] bdiv;
  logic [4:0] bit_cnt;
  logic [12:0] stop_guard;
  logic [10:0] rate_frames;
  logic [SAMPLE_W-1:0] shift;
  logic mclk_en;
  logic mclk_q;
  logic bclk_q;
  logic lr_q;

  wire bclk_en = mclk_en && bclk_run && !rate_change;
  wire mtoggle = mdiv == 4'(MCLK_HALF_CYC - 1);
  wire btoggle = bdiv == 4'(BCLK_HALF_CYC - 1);
  wire bfall = bclk_en && btoggle && bclk_q;
  wire slot_end = bfall && bit_cnt == 5'(BITS_PER_SLOT - 1);
  wire stopping = mclk_en && !mclk_run;
  wire rate_hold = rate_change || rate_frames != 11'h000;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      mdiv <= '0;
      bdiv <= '0;
      mclk_q <= 1'b0;
      bclk_q <= 1'b0;
      lr_q <= 1'b0;
      bit_cnt <= '0;
      shift <= '0;
    end
    else
    begin
      mdiv <= (mtoggle || !mclk_en) ? 4'h0 : mdiv + 4'h1;
      mclk_q <= mclk_en ? (mclk_q ^ mtoggle) : 1'b0;
      bdiv <= (btoggle || !bclk_en) ? 4'h0 : bdiv + 4'h1;
      bclk_q <= bclk_en ? (bclk_q ^ btoggle) : 1'b0;
      if (bfall)
      begin
        bit_cnt <= bit_cnt + 5'h01;
        shift <= {shift[SAMPLE_W-2:0], 1'b0};
      end
      if (slot_end)
      begin
        lr_q <= ~lr_q;
        shift <= audio_word;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      mclk_en <= 1'b0;
      stop_guard <= '0;
      rate_frames <= '0;
    end
    else
    begin
      if (mclk_run)
      begin
        mclk_en <= 1'b1;
        stop_guard <= '0;
      end
      else if (stopping)
      begin
        // Mute is forced first and the master clock runs on for MCLK_STOP_GUARD_CYC more cycles.
        if (stop_guard == 13'(MCLK_STOP_GUARD_CYC - 1))
          mclk_en <= 1'b0;
        else
          stop_guard <= stop_guard + 13'h0001;
      end
      if (rate_change)
        rate_frames <= 11'(RATE_GUARD_FRAMES);
      else if (slot_end && lr_q && rate_frames != 11'h000)
        rate_frames <= rate_frames - 11'h001;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      link.mclk <= 1'b0;
      link.bclk <= 1'b0;
      link.lrclk <= 1'b0;
      link.serial_audio_input <= 1'b0;
      link.mute_n <= 1'b0;
      link.format_select_pin_o <= 1'b0;
      link.format_select_pin_oe <= 1'b0;
      mclk_active <= 1'b0;
      hold_active <= 1'b0;
    end
    else
    begin
      link.mclk <= mclk_q;
      link.bclk <= bclk_q;
      link.lrclk <= lr_q;
      link.serial_audio_input <= shift[SAMPLE_W-1];
      link.mute_n <= !(mute_req || stopping || rate_hold);
      link.format_select_pin_o <= fmt_req == DPS_FMT_I2S;
      link.format_select_pin_oe <= fmt_req != DPS_FMT_RJ;
      mclk_active <= mclk_en;
      hold_active <= stopping || rate_hold;
    end
  end
endmodule : dps_host

// *** verification/dps_chk.sv ***
// Checker for the converter control sequencer: watches the link pins and device outputs.
// Assumes one ref_clk domain; the testbench instantiates it beside the link.
`timescale 1ns/10ps
module dps_chk
  import dps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic mclk,
  input wire logic mute_n,
  input wire logic fmt_level,
  input wire logic fmt_driven,
  input wire dps_state_t power_state,
  input wire logic charge_pump_on,
  input wire logic output_path_on,
  input wire logic [GAIN_W-1:0] gain_left,
  input wire logic [GAIN_W-1:0] gain_right,
  input wire dps_fmt_t audio_format,
  input wire logic bclk_ok
);
  logic mclk_q;
  logic [7:0] idle_cnt;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // The limit allows the watchdog, the synchroniser and the state register.
  always_ff @(posedge ref_clk)
  begin
    mclk_q <= mclk;
    if (!rstn || mclk != mclk_q) idle_cnt <= 8'h00;
    else if (idle_cnt != 8'hff) idle_cnt <= idle_cnt + 8'h01;
  end

  sequence mute_held;
    !mute_n [*7];
  endsequence
  sequence muting_step;
    power_state == DPS_MUTING ##1 power_state == DPS_MUTING;
  endsequence

  gain_pair_a: assert property (gain_left == gain_right)
    else $error("channel gains differ");
  mclk_loss_a: assert property (idle_cnt > 8'h50 |-> power_state == DPS_OFF)
    else $error("stopped master clock did not reach off");
  mute_exit_a: assert property ((power_state == DPS_ENABLED) ##0 mute_held
    |-> power_state != DPS_ENABLED)
    else $error("mute pin low did not leave enabled");
  ramp_step_a: assert property (muting_step |-> gain_left == $past(gain_left)
    || gain_left == $past(gain_left) - 10'h001)
    else $error("gain ramp step is not one");
  no_skip_a: assert property (power_state == DPS_ENABLED |=> power_state != DPS_STANDBY)
    else $error("enabled went to standby without muting");
  full_gain_a: assert property (power_state == DPS_ENABLED ##1 power_state == DPS_ENABLED
    |-> gain_left == GAIN_FULL)
    else $error("enabled without full gain");
  // The bit clock status is registered, so it shows the watchdog's verdict one cycle late.
  standby_hold_a: assert property (power_state == DPS_STANDBY ##1 !bclk_ok
    |-> power_state inside {DPS_STANDBY, DPS_OFF})
    else $error("standby left without bit clock");
  pump_a: assert property (power_state == DPS_STANDBY ##1 power_state == DPS_STANDBY
    |-> charge_pump_on && !output_path_on)
    else $error("standby power outputs wrong");
  path_a: assert property (power_state == DPS_ENABLED ##1 power_state == DPS_ENABLED
    |-> charge_pump_on && output_path_on)
    else $error("enabled power outputs wrong");
  fmt_rj_a: assert property (!fmt_driven [*6] |-> audio_format == DPS_FMT_RJ)
    else $error("floating format pin not decoded");
  fmt_i2s_a: assert property ((fmt_driven && fmt_level) [*6]
    |-> audio_format == DPS_FMT_I2S)
    else $error("high format pin not decoded");
endmodule : dps_chk

// *** verification/tb.sv ***
// Testbench joining host and device through the link, driving the host's user inputs.
// Assumes the fixed host clock ratios: mclk ref/4, bclk ref/16, 1024-cycle frames.
`timescale 1ns/10ps
module tb;
  import dps_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic mclk_run = 1'b0;
  logic bclk_run = 1'b0;
  logic mute_req = 1'b0;
  dps_fmt_t fmt_req = DPS_FMT_LJ;
  logic rate_change = 1'b0;
  logic [SAMPLE_W-1:0] audio_word = 24'h000000;
  logic mclk_active;
  logic hold_active;
  dps_state_t power_state;
  logic charge_pump_on;
  logic output_path_on;
  logic [GAIN_W-1:0] gain_left;
  logic [GAIN_W-1:0] gain_right;
  dps_fmt_t audio_format;
  logic filter_narrow;
  logic mclk_ok;
  logic bclk_ok;
  int fail_count = 0;
  int tests_run = 0;
  int k;

  dps_link_if link();
  dps_host u_dps_host (.ref_clk(ref_clk), .rstn(rstn), .link(link), .mclk_run(mclk_run),
    .bclk_run(bclk_run), .mute_req(mute_req), .fmt_req(fmt_req), .rate_change(rate_change),
    .audio_word(audio_word), .mclk_active(mclk_active), .hold_active(hold_active));
  dps_device u_dps_device (.ref_clk(ref_clk), .rstn(rstn), .link(link),
    .power_state(power_state), .charge_pump_on(charge_pump_on),
    .output_path_on(output_path_on), .gain_left(gain_left), .gain_right(gain_right),
    .audio_format(audio_format), .filter_narrow(filter_narrow), .mclk_ok(mclk_ok),
    .bclk_ok(bclk_ok));
  dps_chk u_dps_chk (.ref_clk(ref_clk), .rstn(rstn), .mclk(link.mclk), .mute_n(link.mute_n),
    .fmt_level(link.fmt_level), .fmt_driven(link.fmt_driven), .power_state(power_state),
    .charge_pump_on(charge_pump_on), .output_path_on(output_path_on), .gain_left(gain_left),
    .gain_right(gain_right), .audio_format(audio_format), .bclk_ok(bclk_ok));

  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) audio_word <= audio_word + 24'h000101;

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Sampling 1 ns after the edge keeps the read clear of that edge's updates.
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic drive(input logic m, input logic b, input logic q);
    @(posedge ref_clk);
    mclk_run <= m;
    bclk_run <= b;
    mute_req <= q;
  endtask : drive

  task automatic wait_st(input dps_state_t s, input int n);
    int i;
    i = 0;
    while (i < n && power_state !== s)
    begin
      cyc(1);
      i++;
    end
  endtask : wait_st

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    cyc(5);
    chk("reset_state", power_state, DPS_OFF);
    @(posedge ref_clk);
    rstn <= 1'b1;
    for (k = 0; k < 3; k++)
    begin
      @(posedge ref_clk);
      fmt_req <= dps_fmt_t'(k);
      cyc(10);
      chk("audio_format", audio_format, dps_fmt_t'(k));
    end
    $display("test format done");
    drive(1'b1, 1'b1, 1'b1);
    wait_st(DPS_STANDBY, 400);
    chk("standby_entry", power_state, DPS_STANDBY);
    chk("pump_standby", charge_pump_on, 1'b1);
    chk("path_standby", output_path_on, 1'b0);
    drive(1'b1, 1'b0, 1'b1);
    cyc(600);
    chk("standby_hold", power_state, DPS_STANDBY);
    chk("bclk_ok_lost", bclk_ok, 1'b0);
    drive(1'b1, 1'b1, 1'b0);
    wait_st(DPS_ENABLED, 400);
    chk("standby_exit", power_state, DPS_ENABLED);
    chk("gain_full", gain_left, GAIN_FULL);
    chk("gain_right", gain_right, GAIN_FULL);
    $display("test standby done");
    drive(1'b1, 1'b1, 1'b1);
    cyc(5140);
    chk("muting", power_state, DPS_MUTING);
    chk("ramp_depth", gain_left >= GAIN_FULL - 10'h006 && gain_left <= GAIN_FULL - 10'h004,
      1'b1);
    drive(1'b1, 1'b1, 1'b0);
    wait_st(DPS_ENABLED, 50);
    chk("unmute_state", power_state, DPS_ENABLED);
    chk("unmute_gain", gain_left, GAIN_FULL);
    $display("test mute done");
    drive(1'b0, 1'b1, 1'b0);
    cyc(10);
    chk("stop_guard", hold_active, 1'b1);
    wait_st(DPS_OFF, MCLK_STOP_GUARD_CYC + 200);
    chk("mclk_lost", power_state, DPS_OFF);
    chk("mclk_ok_lost", mclk_ok, 1'b0);
    chk("pump_off", charge_pump_on, 1'b0);
    chk("mclk_stopped", mclk_active, 1'b0);
    drive(1'b1, 1'b1, 1'b0);
    wait_st(DPS_ENABLED, 400);
    chk("off_to_enabled", power_state, DPS_ENABLED);
    chk("path_enabled", output_path_on, 1'b1);
    chk("mclk_running", mclk_active, 1'b1);
    cyc(2100);
    chk("wide_filter", filter_narrow, 1'b0);
    $display("test power cycle done");
    @(posedge ref_clk);
    rate_change <= 1'b1;
    cyc(100);
    chk("rate_hold", hold_active, 1'b1);
    chk("rate_muting", power_state, DPS_MUTING);
    @(posedge ref_clk);
    rstn <= 1'b0;
    rate_change <= 1'b0;
    cyc(6);
    chk("reset_again", power_state, DPS_OFF);
    @(posedge ref_clk);
    rstn <= 1'b1;
    cyc(2);
    chk("after_release", power_state, DPS_OFF);
    wait_st(DPS_ENABLED, 400);
    chk("reenabled", power_state, DPS_ENABLED);
    $display("test rate and reset done");
    tally_and_finish();
  end

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    $display("[ERR] watchdog expected end seen hang");
    tally_and_finish();
  end
endmodule : tb
